// ---- hdl/sysreg_pkg.sv ----
// Constants for the system register group: register map, field layout,
// reset values and timing of a headset noise-cancelling driver.
// Assumes a 20 MHz system clock and an I2C slave in front of the registers.
package sysreg_pkg;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [7:0] IDENT_ADDR   = 8'h00;
    localparam logic [7:0] STATE_ADDR   = 8'h01;
    localparam logic [7:0] MODE0_ADDR   = 8'h02;
    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int NVM_PASS_BIT   = 4;
    localparam int NVM_IDLE_BIT   = 3;
    localparam int PWRUP_BIT      = 1;
    localparam int KEEP_BIT       = 0;
    localparam int ZCROSS_BIT     = 6;
    localparam int MUXDLY_BIT     = 5;
    localparam int UI_HI_BIT      = 4;
    localparam int UI_LO_BIT      = 3;
    localparam int DISCH_BIT      = 2;
    localparam int HPTYPE_BIT     = 1;
    localparam int HOSTCTL_BIT    = 0;
    // -------------------------------------------------------------------
    // Reset values and writable masks
    // -------------------------------------------------------------------
    localparam logic [7:0] MODE0_RESET  = 8'h4C;
    localparam logic [7:0] MODE0_MASK   = 8'h7F;
    localparam logic       KEEP_RESET   = 1'b1;
    localparam logic [6:0] SLAVE_ADDR   = 7'h40;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int DISCH_MS       = 10;
    localparam int DISCH_CYC      = CLK_HZ / 1000 * DISCH_MS;
    localparam int OFF_TMO_MS     = 50;
    localparam int OFF_TMO_CYC    = CLK_HZ / 1000 * OFF_TMO_MS;
    localparam int MUX_DLY_MS     = 20;
    localparam int MUX_DLY_CYC    = CLK_HZ / 1000 * MUX_DLY_MS;
endpackage : sysreg_pkg

// ---- hdl/i2c_reg_port.sv ----
// I2C slave that gives byte access to a small register file.
// Assumes SCL and SDA arrive already synchronised to CLK; SDA is open drain.
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_port
    import sysreg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_s,
    input  wire logic       sda_s,
    input  wire logic [7:0] rd_data,
    output logic            sda_oe,
    output logic            wr_stb,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    output logic            start_seen
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_ADDR = 4'h1, S_AACK = 4'h2, S_REG = 4'h3,
        S_WACK = 4'h4, S_WDAT = 4'h5, S_RDAT = 4'h6, S_MACK = 4'h7,
        S_MOK  = 4'h8
    } port_state_t;

    port_state_t state_q, state_d;
    logic        scl_p_q, sda_p_q, oe_q, oe_d, rw_q, rw_d, stb_q, stb_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d, ptr_q, ptr_d;
    logic        rise, fall, start, stop;

    // -------------------------------------------------------------------
    // Bus events; previous copies come from the second synchroniser stage
    // -------------------------------------------------------------------
    assign rise  = scl_s & ~scl_p_q;
    assign fall  = ~scl_s & scl_p_q;
    assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Byte engine: sample on SCL rise, change SDA only on SCL fall
    always_comb
    begin
        state_d = state_q;
        oe_d    = oe_q;
        rw_d    = rw_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        stb_d   = 1'b0;
        if (start)
        begin
            state_d = S_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end
        else if (stop)
        begin
            state_d = S_IDLE;
            oe_d    = 1'b0;
        end
        else if (rise)
        begin
            case (state_q)
                S_ADDR, S_REG, S_WDAT:
                begin
                    sh_d  = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 4'h1;
                end
                S_RDAT: cnt_d = cnt_q + 4'h1;
                S_MACK:
                begin
                    // A NACK from the master ends the read burst
                    state_d = sda_s ? S_IDLE : S_MOK;
                    ptr_d   = sda_s ? ptr_q : ptr_q + 8'h01;
                end
                default: ;
            endcase
        end
        else if (fall)
        begin
            case (state_q)
                S_ADDR:
                    if (cnt_q == 4'h8)
                    begin
                        state_d = (sh_q[7:1] == SLAVE_ADDR) ? S_AACK : S_IDLE;
                        oe_d    = (sh_q[7:1] == SLAVE_ADDR);
                        rw_d    = sh_q[0];
                    end
                S_REG:
                    if (cnt_q == 4'h8)
                    begin
                        ptr_d   = sh_q;
                        oe_d    = 1'b1;
                        state_d = S_WACK;
                    end
                S_WDAT:
                    if (cnt_q == 4'h8)
                    begin
                        stb_d   = 1'b1;
                        oe_d    = 1'b1;
                        state_d = S_WACK;
                    end
                S_WACK:
                begin
                    oe_d    = 1'b0;
                    cnt_d   = 4'h0;
                    state_d = S_WDAT;
                    ptr_d   = stb_q ? ptr_q + 8'h01 : ptr_q;
                end
                S_RDAT:
                    if (cnt_q == 4'h8)
                    begin
                        oe_d    = 1'b0;
                        state_d = S_MACK;
                    end
                    else
                    begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                S_AACK, S_MOK:
                    if (state_q == S_AACK && !rw_q)
                    begin
                        oe_d    = 1'b0;
                        cnt_d   = 4'h0;
                        state_d = S_REG;
                    end
                    else
                    begin
                        sh_d    = rd_data;
                        oe_d    = ~rd_data[7];
                        cnt_d   = 4'h0;
                        state_d = S_RDAT;
                    end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            oe_q    <= 1'b0;
            rw_q    <= 1'b0;
            stb_q   <= 1'b0;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            oe_q    <= oe_d;
            rw_q    <= rw_d;
            stb_q   <= stb_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
        end
    end

    assign sda_oe     = oe_q;
    assign wr_stb     = stb_q;
    assign wr_addr    = ptr_q;
    assign wr_data    = sh_q;
    assign rd_addr    = ptr_q;
    assign start_seen = start;
endmodule : i2c_reg_port
`default_nettype wire

// ---- hdl/system_status_mode_registers.sv ----
// System register group: identification, system state and first mode
// register, with power hold, wake-up, discharge and mux-delay control.
// Assumes status inputs and I2C pins are asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module system_status_mode_registers
    import sysreg_pkg::*;
#(
    parameter logic [3:0] VERSION_CODE = 4'hA, // Arbitrary value
    parameter logic [3:0] PART_CODE    = 4'h5, // Arbitrary value
    parameter int         DISCH_CYCLES = DISCH_CYC,
    parameter int         OFF_CYCLES   = OFF_TMO_CYC,
    parameter int         MUX_CYCLES   = MUX_DLY_CYC
)
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    input  wire logic       NVM_TEST_PASS,
    input  wire logic       NVM_IDLE,
    input  wire logic       POWERUP_DONE,
    input  wire logic       MIC_SUPPLY_ON,
    output logic            POWER_ENABLE,
    output logic            HOST_CONTROL,
    output logic            ZERO_CROSS_EN,
    output logic            HP_MUX_APPLY,
    output logic [1:0]      UI_SELECT,
    output logic            MIC_DISCHARGE,
    output logic            HP_DIFF_RIGHT_ONLY
);
    localparam logic [23:0] DISCH_LAST = 24'(DISCH_CYCLES - 1);
    localparam logic [23:0] OFF_LAST   = 24'(OFF_CYCLES - 1);
    localparam logic [23:0] MUX_LAST   = 24'(MUX_CYCLES - 1);

    // -------------------------------------------------------------------
    // Input synchronisers; stage one is read only by stage two
    // -------------------------------------------------------------------
    logic [5:0] s1_q, s2_q;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s1_q <= 6'h3D; // Power-up flag resets low: a high level would fake a startup
            s2_q <= 6'h3D;
        end
        else
        begin
            s1_q <= {SCL, SDA_I, NVM_TEST_PASS, NVM_IDLE, POWERUP_DONE, MIC_SUPPLY_ON};
            s2_q <= s1_q;
        end
    end

    logic       sda_oe, wr_stb, start_seen;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;

    i2c_reg_port u_port (
        .clk        (CLK),
        .rst        (RST),
        .scl_s      (s2_q[5]),
        .sda_s      (s2_q[4]),
        .rd_data    (rd_data),
        .sda_oe     (sda_oe),
        .wr_stb     (wr_stb),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .rd_addr    (rd_addr),
        .start_seen (start_seen)
    );

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    logic [7:0] mode_q, mode_d;
    logic       keep_q, keep_d, keep_wr;

    // Writes land whatever the host control bit says
    always_comb
    begin
        mode_d  = mode_q;
        keep_d  = keep_q;
        keep_wr = wr_stb && (wr_addr == STATE_ADDR);
        if (wr_stb && wr_addr == MODE0_ADDR)
            mode_d = wr_data & MODE0_MASK;
        if (keep_wr)
            keep_d = wr_data[KEEP_BIT];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mode_q <= MODE0_RESET;
            keep_q <= KEEP_RESET;
        end
        else
        begin
            mode_q <= mode_d;
            keep_q <= keep_d;
        end
    end

    // Read mux; unmapped addresses and unused bits read zero
    always_comb
    begin
        case (rd_addr)
            IDENT_ADDR: rd_data = {VERSION_CODE, PART_CODE};
            STATE_ADDR:
            begin
                rd_data               = 8'h00;
                rd_data[NVM_PASS_BIT] = s2_q[3];
                rd_data[NVM_IDLE_BIT] = s2_q[2];
                rd_data[PWRUP_BIT]    = s2_q[1];
                rd_data[KEEP_BIT]     = keep_q;
            end
            MODE0_ADDR: rd_data = mode_q;
            default:    rd_data = 8'h00;
        endcase
    end

    // -------------------------------------------------------------------
    // Power hold, wake on start, shutdown timeout
    // -------------------------------------------------------------------
    logic        power_q, power_d, waking_q, waking_d;
    logic [23:0] tmo_q, tmo_d;

    // The keep bit stays zero after a wake, so it is ignored while waking
    always_comb
    begin
        power_d  = power_q;
        waking_d = waking_q;
        tmo_d    = tmo_q;
        if (!mode_q[HOSTCTL_BIT])
        begin
            power_d  = 1'b1;
            waking_d = 1'b0;
        end
        else if (!power_q)
        begin
            if (start_seen)
            begin
                power_d  = 1'b1;
                waking_d = 1'b1;
                tmo_d    = 24'h000000;
            end
        end
        else if (waking_q)
        begin
            if (keep_wr && wr_data[KEEP_BIT])
                waking_d = 1'b0;
            else if (tmo_q == OFF_LAST)
            begin
                power_d  = 1'b0;
                waking_d = 1'b0;
            end
            else
                tmo_d = tmo_q + 24'h000001;
        end
        else if (!keep_q)
            power_d = 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            power_q  <= 1'b1;
            waking_q <= 1'b0;
            tmo_q    <= 24'h000000;
        end
        else
        begin
            power_q  <= power_d;
            waking_q <= waking_d;
            tmo_q    <= tmo_d;
        end
    end

    // -------------------------------------------------------------------
    // Mic supply discharge and headphone mux startup delay
    // -------------------------------------------------------------------
    logic        mic_p_q, dis_q, dis_d, started_q, started_d;
    logic        dly_q, dly_d, mux_q, mux_d;
    logic [23:0] dcnt_q, dcnt_d, mcnt_q, mcnt_d;

    // Discharge is timed, not sensed: the pin has no level feedback here
    always_comb
    begin
        dis_d     = dis_q;
        dcnt_d    = dcnt_q;
        started_d = started_q;
        dly_d     = dly_q;
        mux_d     = mux_q;
        mcnt_d    = mcnt_q;
        if (s2_q[0])
            dis_d = 1'b0;
        else if (mic_p_q && mode_q[DISCH_BIT])
        begin
            dis_d  = 1'b1;
            dcnt_d = 24'h000000;
        end
        else if (dis_q)
        begin
            dis_d  = (dcnt_q != DISCH_LAST);
            dcnt_d = dcnt_q + 24'h000001;
        end
        if (!started_q && s2_q[1])
        begin
            started_d = 1'b1;
            dly_d     = mode_q[MUXDLY_BIT];
            mux_d     = !mode_q[MUXDLY_BIT];
            mcnt_d    = 24'h000000;
        end
        else if (dly_q)
        begin
            dly_d  = (mcnt_q != MUX_LAST);
            mux_d  = (mcnt_q == MUX_LAST);
            mcnt_d = mcnt_q + 24'h000001;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mic_p_q   <= 1'b1;
            dis_q     <= 1'b0;
            dcnt_q    <= 24'h000000;
            started_q <= 1'b0;
            dly_q     <= 1'b0;
            mux_q     <= 1'b0;
            mcnt_q    <= 24'h000000;
        end
        else
        begin
            mic_p_q   <= s2_q[0];
            dis_q     <= dis_d;
            dcnt_q    <= dcnt_d;
            started_q <= started_d;
            dly_q     <= dly_d;
            mux_q     <= mux_d;
            mcnt_q    <= mcnt_d;
        end
    end

    // -------------------------------------------------------------------
    // Outputs: SDA_O tied low, all others from flip-flops
    // -------------------------------------------------------------------
    assign SDA_O              = 1'b0;
    assign SDA_OE             = sda_oe;
    assign POWER_ENABLE       = power_q;
    assign HOST_CONTROL       = mode_q[HOSTCTL_BIT];
    assign ZERO_CROSS_EN      = mode_q[ZCROSS_BIT];
    assign HP_MUX_APPLY       = mux_q;
    assign UI_SELECT          = mode_q[UI_HI_BIT:UI_LO_BIT];
    assign MIC_DISCHARGE      = dis_q;
    assign HP_DIFF_RIGHT_ONLY = mode_q[HPTYPE_BIT];

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence keep_zero_write;
        wr_stb && wr_addr == STATE_ADDR && !wr_data[KEEP_BIT] && !waking_q;
    endsequence

    a_id_value: assert property (rd_addr == IDENT_ADDR |-> rd_data == {VERSION_CODE, PART_CODE})
        else $error("identification read wrong");
    a_state_bits: assert property (rd_addr == STATE_ADDR |-> rd_data[7:5] == 3'h0 && rd_data[2] == 1'b0 && rd_data[4:3] == s2_q[3:2])
        else $error("state register read wrong");
    a_pwrup_bit: assert property (rd_addr == STATE_ADDR |-> rd_data[PWRUP_BIT] == s2_q[1])
        else $error("power-up flag read wrong");
    a_keep_off: assert property ((keep_zero_write and (mode_q[HOSTCTL_BIT] && power_q)) ##1 mode_q[HOSTCTL_BIT] |=> !power_q)
        else $error("power not dropped after keep cleared");
    a_wake_start: assert property (!power_q && start_seen && mode_q[HOSTCTL_BIT] |=> power_q && waking_q)
        else $error("start condition did not wake");
    a_host_gate: assert property (!mode_q[HOSTCTL_BIT] |=> power_q)
        else $error("power dropped without host control");
    a_wake_tmo: assert property (waking_q && tmo_q == OFF_LAST && mode_q[HOSTCTL_BIT] && !(keep_wr && wr_data[KEEP_BIT]) |=> !power_q)
        else $error("no power down after wake timeout");
    a_disch_start: assert property (mic_p_q && !s2_q[0] && mode_q[DISCH_BIT] |=> dis_q)
        else $error("discharge did not start");
    a_mode_mask: assert property (wr_stb && wr_addr == MODE0_ADDR |=> mode_q == (($past(wr_data)) & MODE0_MASK))
        else $error("mode write not masked");
    a_mux_nodly: assert property (!started_q && s2_q[1] && !mode_q[MUXDLY_BIT] |=> mux_q)
        else $error("mux not applied at startup");
endmodule : system_status_mode_registers
`default_nettype wire

// ---- bench/i2c_host_model.sv ----
// Host controller model: master on the two-wire register bus.
// Assumes the bench resolves the pulled-up data line from all drivers.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
    import sysreg_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low
);
    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    // Bus idle at time zero: clock high, data released
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Changes happen on falling edges, away from the sampling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // Works as start and as repeated start, since data is released first
    task automatic start_c;
        sda_low = 1'b0;
        wt(5);
        scl = 1'b1;
        wt(10);
        sda_low = 1'b1;
        wt(10);
        scl = 1'b0;
        wt(5);
    endtask : start_c
    task automatic stop_c;
        sda_low = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(10);
        sda_low = 1'b0;
        wt(10);
    endtask : stop_c
    // High phase of 10 cycles; the wire is sampled in its middle
    task automatic bit_x(input logic b, output logic r);
        sda_low = !b;
        wt(5);
        scl = 1'b1;
        wt(5);
        r = sda;
        wt(5);
        scl = 1'b0;
        wt(5);
    endtask : bit_x
    // Sending all ones releases the line, so this also reads a byte
    task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                          output logic k);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(a, k);
    endtask : byte_x
    // ------------------------------------------------------------
    // Register transfers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        start_c();
        byte_x({SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
        byte_x(a, 1'b1, q, k[1]);
        byte_x(d, 1'b1, q, k[2]);
        stop_c();
        ok = (k === 3'b000);
    endtask : wr
    // Last byte is refused so the device lets go before the stop
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        logic       k;
        start_c();
        byte_x({SLAVE_ADDR, 1'b0}, 1'b1, q, k);
        byte_x(a, 1'b1, q, k);
        start_c();
        byte_x({SLAVE_ADDR, 1'b1}, 1'b1, q, k);
        byte_x(8'hFF, 1'b1, d, k);
        stop_c();
    endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// ---- bench/tb_system_status_mode_registers.sv ----
// Testbench for the system register group, driven through a bus master model.
// Assumes shortened discharge, shutdown and mux delays set below.
`timescale 1ns/1ps
`default_nettype none
module tb_system_status_mode_registers;
    import sysreg_pkg::*;
    localparam int         DC    = 20;
    localparam int         OC    = 2000;
    localparam int         MC    = 30;
    localparam logic [3:0] VC    = 4'h3; // Arbitrary value
    localparam logic [3:0] PC    = 4'hC; // Arbitrary value
    localparam int         LIMIT = 40000;
    logic CLK = 1'b0, RST = 1'b1, SCL, SDA_I, SDA_OE, host_low;
    logic NVM_TEST_PASS, NVM_IDLE, POWERUP_DONE, MIC_SUPPLY_ON, POWER_ENABLE;
    logic HOST_CONTROL, ZERO_CROSS_EN, HP_MUX_APPLY, MIC_DISCHARGE, HP_DIFF_RIGHT_ONLY;
    logic [1:0]  UI_SELECT;
    logic [7:0]  mode_m;
    logic [31:0] rnd = 32'h0001470D;
    int          mismatches = 0, n_compared = 0, cycles = 0;
    // ------------------------------------------------------------
    // Clock, wired data line and instances
    // ------------------------------------------------------------
    always #25 CLK = !CLK;
    // Pull-up: the line is low only while someone pulls it
    assign SDA_I = !(host_low | SDA_OE);
    system_status_mode_registers #(.VERSION_CODE(VC), .PART_CODE(PC), .DISCH_CYCLES(DC),
        .OFF_CYCLES(OC), .MUX_CYCLES(MC)) system_status_mode_registers_inst (.CLK(CLK),
        .RST(RST), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(), .SDA_OE(SDA_OE),
        .NVM_TEST_PASS(NVM_TEST_PASS), .NVM_IDLE(NVM_IDLE), .POWERUP_DONE(POWERUP_DONE),
        .MIC_SUPPLY_ON(MIC_SUPPLY_ON), .POWER_ENABLE(POWER_ENABLE),
        .HOST_CONTROL(HOST_CONTROL), .ZERO_CROSS_EN(ZERO_CROSS_EN),
        .HP_MUX_APPLY(HP_MUX_APPLY), .UI_SELECT(UI_SELECT), .MIC_DISCHARGE(MIC_DISCHARGE),
        .HP_DIFF_RIGHT_ONLY(HP_DIFF_RIGHT_ONLY));
    i2c_host_model i2c_host_model_inst (.clk(CLK), .sda(SDA_I), .scl(SCL), .sda_low(host_low));
    // ------------------------------------------------------------
    // Checking helpers and reference model
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic print_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i2c_host_model_inst.wr(a, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i2c_host_model_inst.rd(a, d);
        chk(d, e);
    endtask : rd_chk
    // Expected state byte: unused bits zero, live inputs, stored keep bit
    function automatic logic [7:0] st(input logic k);
        return {3'b000, NVM_TEST_PASS, NVM_IDLE, 1'b0, POWERUP_DONE, k};
    endfunction : st
    // Mode outputs follow the stored mode byte; discharge idle
    function automatic logic [7:0] outs_e(input logic [7:0] m, input logic pe, input logic ap);
        return {pe, m[0], m[6], m[4:3], 1'b0, m[1], ap};
    endfunction : outs_e
    task automatic outs_chk(input logic [7:0] e);
        chk({POWER_ENABLE, HOST_CONTROL, ZERO_CROSS_EN, UI_SELECT, MIC_DISCHARGE,
             HP_DIFF_RIGHT_ONLY, HP_MUX_APPLY}, e);
    endtask : outs_chk
    // Hang guard: the full sequence needs about three fifths of this many cycles
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        NVM_TEST_PASS = 1'b0;
        NVM_IDLE = 1'b0;
        POWERUP_DONE = 1'b0;
        MIC_SUPPLY_ON = 1'b1;
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        repeat (4) @(negedge CLK);
        outs_chk(outs_e(8'h4C, 1'b1, 1'b0));
        MIC_SUPPLY_ON = 1'b0;
        repeat (8) @(negedge CLK);
        chk({7'h00, MIC_DISCHARGE}, 8'h01);
        repeat (DC + 10) @(negedge CLK);
        chk({7'h00, MIC_DISCHARGE}, 8'h00);
        // Identification is fixed; a write there must not stick
        rd_chk(IDENT_ADDR, {VC, PC});
        wr(IDENT_ADDR, 8'hFF);
        rd_chk(IDENT_ADDR, {VC, PC});
        rd_chk(MODE0_ADDR, 8'h4C);
        rd_chk(8'h05, 8'h00);
        // Delay bit set before first power-up holds the mux selection back
        wr(MODE0_ADDR, 8'hEC);
        rd_chk(MODE0_ADDR, 8'h6C);
        POWERUP_DONE = 1'b1;
        repeat (MC - 5) @(negedge CLK);
        chk({7'h00, HP_MUX_APPLY}, 8'h00);
        repeat (15) @(negedge CLK);
        chk({7'h00, HP_MUX_APPLY}, 8'h01);
        // Random mode bytes; every interface mode code is visited once
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            mode_m = {1'b0, rnd[6:5], i[1:0], rnd[2:0]};
            wr(MODE0_ADDR, {rnd[7], mode_m[6:0]});
            rd_chk(MODE0_ADDR, mode_m);
            NVM_TEST_PASS = rnd[8];
            NVM_IDLE = rnd[9];
            MIC_SUPPLY_ON = 1'b1;
            repeat (5) @(negedge CLK);
            MIC_SUPPLY_ON = 1'b0;
            repeat (8) @(negedge CLK);
            chk({7'h00, MIC_DISCHARGE}, {7'h00, mode_m[2]});
            repeat (DC + 10) @(negedge CLK);
            outs_chk(outs_e(mode_m, 1'b1, 1'b1));
            rd_chk(STATE_ADDR, st(1'b1));
        end
        // Keep bit ignored without host control, obeyed with it
        wr(MODE0_ADDR, 8'h4C);
        wr(STATE_ADDR, 8'h00);
        repeat (5) @(negedge CLK);
        chk({7'h00, POWER_ENABLE}, 8'h01);
        rd_chk(STATE_ADDR, st(1'b0));
        wr(STATE_ADDR, 8'h01);
        wr(MODE0_ADDR, 8'h4D);
        wr(STATE_ADDR, 8'h00);
        repeat (5) @(negedge CLK);
        chk({7'h00, POWER_ENABLE}, 8'h00);
        // A bare start wakes the chip; no keep write lets it drop again
        i2c_host_model_inst.start_c();
        i2c_host_model_inst.stop_c();
        chk({7'h00, POWER_ENABLE}, 8'h01);
        repeat (OC - 300) @(negedge CLK);
        chk({7'h00, POWER_ENABLE}, 8'h01);
        repeat (400) @(negedge CLK);
        chk({7'h00, POWER_ENABLE}, 8'h00);
        // Host keeps the promise this time, well within the timeout
        wr(STATE_ADDR, 8'h01);
        repeat (OC + 50) @(negedge CLK);
        chk({7'h00, POWER_ENABLE}, 8'h01);
        rd_chk(STATE_ADDR, st(1'b1));
        // Mid-run reset with power-up already done: delay bit clear, mux applies at once
        RST = 1'b1;
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        @(negedge CLK);
        chk({7'h00, HP_MUX_APPLY}, 8'h00);
        repeat (3) @(negedge CLK);
        chk({7'h00, HP_MUX_APPLY}, 8'h01);
        print_verdict();
    end
endmodule : tb_system_status_mode_registers
`default_nettype wire
